// ===== logic/maac_checker.sv
// Memory access checker: forms the effective address, checks alignment,
// range and space-id privilege, tags the address and orders bytes.
// Assumes the load/store pipeline holds request fields for one clk cycle
// and that all inputs are synchronous to clk.
// ------------------------------------------------------------
// Functional notes
// ------------------------------------------------------------
// Functional notes
// - Aligned only when address is a multiple of the datum size.
// - Misaligned load, store or atomic raises a fault, access not issued.
// - Data defaults to big-endian: address holds most significant byte.
// - Instruction fetches always use big-endian byte order.
// - Data may use little-endian: address holds least significant byte.
// - Only the low and high halves of the n-bit space are accepted.
// - Alternate accesses carry an explicit 8-bit space id.
// - Space ids 00 to 2F need privileged or hyperprivileged mode.
// - Ids 30 to 7F need hyperprivileged mode; 80 to FF are open.
// - Some ids reach protected implementation registers.
// - Atomic operations accept explicit space ids with the same checks.
// - I/O registers reached via alternate, normal or ancillary access.
// - Instruction view made consistent only after an explicit flush.
// - A flush discards stale fetched instructions in the buffers.
// - Address is reg plus reg, or reg plus sign-extended 13-bit imm.
// - Every issued address carries a space id.
module maac_checker
    import maac_pkg::*;
#(
    parameter int VA_BITS = VA_BITS_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Request from the pipeline
    input wire logic reqValid,
    input wire maac_op_t reqOp,
    input wire maac_size_t reqSize,
    input wire logic [ADDR_W-1:0] reqBase,
    input wire logic [ADDR_W-1:0] reqIndex,
    input wire logic [IMM_W-1:0] reqImm,
    input wire logic reqUseImm,
    input wire logic reqAlt,
    input wire logic [SPACE_ID_W-1:0] reqSpaceId,
    input wire logic [ADDR_W-1:0] reqStoreData,
    input wire logic dataLittle,
    input wire maac_mode_t privMode,
    // Flush request
    input wire logic flushReq,
    // Issued access
    output logic issValid,
    output maac_op_t issOp,
    output logic [ADDR_W-1:0] issAddr,
    output logic [SPACE_ID_W-1:0] issSpaceId,
    output logic [ADDR_W-1:0] issData,
    output logic issImplRegs,
    // Fault report
    output logic faultValid,
    output logic [2:0] faultCode,
    output logic [ADDR_W-1:0] faultAddr,
    // Flush effects
    output logic fetchBufDiscard,
    output logic fetchStale
);
    // ------------------------------------------------------------
    // Combinational checks
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] effAddr;
    logic [ADDR_W-1:0] offset;
    logic [SPACE_ID_W-1:0] spaceId;
    logic misaligned;
    logic inHole;
    logic privFail;
    logic isFetch;
    logic isAnc;
    logic [ADDR_W-1:0] swapped;
    logic [ADDR_W-VA_BITS:0] topBits;

    // Sign-extended immediate or second register
    assign offset = reqUseImm ?
        {{(ADDR_W-IMM_W){reqImm[IMM_W-1]}}, reqImm} : reqIndex;
    assign effAddr = reqBase + offset;
    assign isFetch = (reqOp == MAAC_OP_FETCH);
    assign isAnc = (reqOp == MAAC_OP_ANC_RD) || (reqOp == MAAC_OP_ANC_WR);

    // Size-based low-bit check; ancillary accesses carry no address
    always_comb begin
        unique case (reqSize)
            MAAC_SZ_BYTE: misaligned = 1'b0;
            MAAC_SZ_HALF: misaligned = effAddr[0];
            MAAC_SZ_WORD: misaligned = |effAddr[1:0];
            MAAC_SZ_DWORD: misaligned = |effAddr[2:0];
        endcase
        if (isAnc) begin
            misaligned = 1'b0;
        end
    end

    // Upper bits must all match bit n-1 to fall outside the hole
    assign topBits = effAddr[ADDR_W-1:VA_BITS-1];
    assign inHole = !isAnc && !(&topBits) && (|topBits);

    // Alternate forms, atomics included, use the explicit id; fetch and ancillary never do
    always_comb begin
        if (reqAlt && !isFetch && !isAnc) begin
            spaceId = reqSpaceId;
        end else if (dataLittle && !isFetch) begin
            spaceId = SPACE_DEFAULT_LE;
        end else begin
            spaceId = SPACE_DEFAULT_BE;
        end
    end

    // Only explicit ids are privilege-checked; defaults are open spaces
    always_comb begin
        privFail = 1'b0;
        if (reqAlt && !isFetch && !isAnc) begin
            if (spaceId <= SPACE_PRIV_LAST) begin
                privFail = (privMode == MAAC_USER);
            end else if (spaceId <= SPACE_HYP_LAST) begin
                privFail = (privMode != MAAC_HYP);
            end
        end
    end

    // Byte lanes reversed for little-endian data; fetches never swap
    generate
        for (genvar b = 0; b < 8; b++) begin : g_swap
            assign swapped[8*b +: 8] = reqStoreData[8*(7-b) +: 8];
        end
    endgenerate

    // ------------------------------------------------------------
    // Issue and fault registers
    // ------------------------------------------------------------
    logic anyFault;
    assign anyFault = misaligned || inHole || privFail;

    // Faulting requests are never issued, so no partial access occurs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            issValid <= 1'b0;
            issOp <= MAAC_OP_LOAD;
            issAddr <= '0;
            issSpaceId <= '0;
            issData <= '0;
            issImplRegs <= 1'b0;
        end else begin
            issValid <= reqValid && !anyFault;
            issOp <= reqOp;
            issAddr <= effAddr;
            issSpaceId <= spaceId;
            issImplRegs <= (spaceId == SPACE_IMPL_REGS);
            if (dataLittle && !isFetch) begin
                issData <= swapped;
            end else begin
                issData <= reqStoreData;
            end
        end
    end

    // Fault report, one cycle after the request
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            faultValid <= 1'b0;
            faultCode <= '0;
            faultAddr <= '0;
        end else begin
            faultValid <= reqValid && anyFault;
            faultCode[FLT_ALIGN] <= reqValid && misaligned;
            faultCode[FLT_HOLE] <= reqValid && inHole;
            faultCode[FLT_PRIV] <= reqValid && privFail;
            faultAddr <= effAddr;
        end
    end

    // ------------------------------------------------------------
    // Flush handling
    // ------------------------------------------------------------
    logic storeIssued;
    assign storeIssued = reqValid && !anyFault && !isFetch &&
        (reqOp != MAAC_OP_LOAD) && (reqOp != MAAC_OP_ANC_RD);

    // Stale marks code possibly modified; set wins over a same-cycle flush
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fetchStale <= 1'b0;
        end else if (storeIssued) begin
            fetchStale <= 1'b1;
        end else if (flushReq) begin
            fetchStale <= 1'b0;
        end
    end

    // Discard pulse goes out on every flush, coherent or not
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fetchBufDiscard <= 1'b0;
        end else begin
            fetchBufDiscard <= flushReq;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_word_align: assert property (reqValid &&
        reqSize == MAAC_SZ_WORD && !isAnc && effAddr[1:0] != 2'b00
        |=> faultValid && !issValid)
        else $error("misaligned word not faulted");
    a_fault_blocks: assert property (faultValid |-> !issValid)
        else $error("faulted access was issued");
    a_user_low_id: assert property (reqValid && reqAlt &&
        !isFetch && !isAnc && privMode == MAAC_USER &&
        reqSpaceId <= SPACE_PRIV_LAST |=> faultCode[FLT_PRIV])
        else $error("user access to low id not blocked");
    a_priv_mid_id: assert property (reqValid && reqAlt &&
        !isFetch && !isAnc && privMode == MAAC_PRIV &&
        reqSpaceId > SPACE_PRIV_LAST && reqSpaceId <= SPACE_HYP_LAST
        |=> faultCode[FLT_PRIV])
        else $error("privileged access to mid id not blocked");
    a_open_id: assert property (reqValid && reqAlt &&
        reqSpaceId > SPACE_HYP_LAST |=> !faultCode[FLT_PRIV])
        else $error("open id wrongly blocked");
    a_hole_block: assert property (reqValid && inHole
        |=> faultCode[FLT_HOLE] && !issValid)
        else $error("hole address not blocked");
    a_fetch_order: assert property (reqValid && isFetch
        |=> issData == $past(reqStoreData))
        else $error("fetch data reordered");
    a_le_swap: assert property (reqValid && dataLittle &&
        !isFetch |=> issData[7:0] == $past(reqStoreData[63:56]))
        else $error("little-endian lane wrong");
    a_alt_id: assert property (reqValid && reqAlt && !isFetch &&
        !isAnc && !anyFault |=> issValid && issSpaceId == $past(reqSpaceId))
        else $error("explicit id not carried");
    a_flush_clear: assert property (flushReq && !storeIssued
        |=> !fetchStale && fetchBufDiscard)
        else $error("flush did not clear");
    a_store_stale: assert property (storeIssued |=> fetchStale)
        else $error("store did not mark stale");

    c_alt_ok: cover property (issValid && issSpaceId < 8'h80);
    c_align_flt: cover property (faultValid && faultCode[0]);
    c_hole_flt: cover property (faultValid && faultCode[1]);
    c_flush: cover property (fetchStale ##1 fetchBufDiscard);
endmodule

// ===== include/maac_pkg.sv
// Package for the memory access address and space-id checker.
// Assumes a single core clock domain; shared by the checker and its bench.
package maac_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 64;
    localparam int SPACE_ID_W = 8;
    localparam int IMM_W = 13;
    localparam int VA_BITS_DEF = 48;
    // ------------------------------------------------------------
    // Space-id privilege boundaries
    // ------------------------------------------------------------
    localparam logic [7:0] SPACE_PRIV_LAST = 8'h2F;
    localparam logic [7:0] SPACE_HYP_LAST = 8'h7F;
    // Default space ids, arbitrary neutral values
    localparam logic [7:0] SPACE_DEFAULT_BE = 8'h80;
    localparam logic [7:0] SPACE_DEFAULT_LE = 8'h88;
    // Implementation-specific protected space (arbitrary value)
    localparam logic [7:0] SPACE_IMPL_REGS = 8'h45;
    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MAAC_USER, MAAC_PRIV, MAAC_HYP
    } maac_mode_t;
    typedef enum logic [1:0] {
        MAAC_SZ_BYTE, MAAC_SZ_HALF, MAAC_SZ_WORD, MAAC_SZ_DWORD
    } maac_size_t;
    typedef enum logic [2:0] {
        MAAC_OP_LOAD, MAAC_OP_STORE, MAAC_OP_LDST_UB, MAAC_OP_CAS_W,
        MAAC_OP_CAS_X, MAAC_OP_FETCH, MAAC_OP_ANC_RD, MAAC_OP_ANC_WR
    } maac_op_t;
    // Fault code bit positions
    localparam int FLT_ALIGN = 0;
    localparam int FLT_HOLE = 1;
    localparam int FLT_PRIV = 2;
endpackage

// ===== verification/maac_pipe_model.sv
// Load/store pipeline model that issues requests to the access checker.
// Assumes tasks are called at a falling clk edge; send returns two later.
module maac_pipe_model
    import maac_pkg::*;
(
    // Clock
    input wire logic clk,
    // Request to the checker
    output logic reqValid,
    output maac_op_t reqOp,
    output maac_size_t reqSize,
    output logic [63:0] reqBase,
    output logic [63:0] reqIndex,
    output logic [12:0] reqImm,
    output logic reqUseImm,
    output logic reqAlt,
    output logic [7:0] reqSpaceId,
    output logic [63:0] reqStoreData,
    // Side inputs, set by the bench between requests
    output logic dataLittle,
    output maac_mode_t privMode,
    output logic flushReq
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------------------------------
    // Idle values
    // --------------------------------------------------------
    initial begin
        {reqValid, reqUseImm, reqAlt, dataLittle, flushReq} = 5'h00;
        {reqBase, reqIndex, reqStoreData} = '0;
        {reqImm, reqSpaceId} = '0;
        reqOp = MAAC_OP_LOAD;
        reqSize = MAAC_SZ_BYTE;
        privMode = MAAC_USER;
    end
    // One request, raised a falling edge after the call and held for the
    // single edge that takes it; the first wait keeps back-to-back calls
    // from raising reqValid in the step that lowered it. Afterwards
    // the operands flip so a stale sample never looks valid
    task automatic send(maac_op_t op, maac_size_t sz, logic [63:0] b,
        logic [63:0] x, logic [12:0] imm, logic useImm, logic alt,
        logic [7:0] id, logic [63:0] d);
        @(negedge clk);
        reqValid = 1'b1;
        {reqOp, reqSize, reqBase, reqIndex} = {op, sz, b, x};
        {reqImm, reqUseImm, reqAlt, reqSpaceId} = {imm, useImm, alt, id};
        reqStoreData = d;
        @(negedge clk);
        reqValid = 1'b0;
        {reqBase, reqIndex, reqStoreData} = {~b, ~x, ~d};
    endtask
    // Flush pulse of one cycle
    task automatic flush();
        flushReq = 1'b1;
        @(negedge clk);
        flushReq = 1'b0;
    endtask
    // Side inputs, changed only between requests
    task automatic setMode(maac_mode_t m);
        privMode = m;
    endtask
    task automatic setLittle(logic le);
        dataLittle = le;
    endtask
endmodule

// ===== verification/maac_checker_tb.sv
// Self-checking bench for the memory access checker.
// Assumes the pipeline model drives all requests at falling edges.
module maac_checker_tb import maac_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int VA = VA_BITS_DEF;
    logic clk, arst_n, reqValid, reqUseImm, reqAlt, dataLittle, flushReq;
    logic issValid, issImplRegs, faultValid, fetchBufDiscard, fetchStale;
    maac_op_t reqOp, issOp;
    maac_size_t reqSize;
    maac_mode_t privMode;
    logic [63:0] reqBase, reqIndex, reqStoreData, issAddr, issData, faultAddr;
    logic [12:0] reqImm;
    logic [7:0] reqSpaceId, issSpaceId;
    logic [2:0] faultCode;
    logic [63:0] lo, hi;
    logic [7:0] ids [4] = '{8'h2F, 8'h30, 8'h7F, 8'h80};
    int nFail = 0;
    int testsRun = 0;
    // --------------------------------------------------------
    // Instances
    // --------------------------------------------------------
    maac_pipe_model u_maac_pipe_model (
        .clk(clk),
        .reqValid(reqValid),
        .reqOp(reqOp),
        .reqSize(reqSize),
        .reqBase(reqBase),
        .reqIndex(reqIndex),
        .reqImm(reqImm),
        .reqUseImm(reqUseImm),
        .reqAlt(reqAlt),
        .reqSpaceId(reqSpaceId),
        .reqStoreData(reqStoreData),
        .dataLittle(dataLittle),
        .privMode(privMode),
        .flushReq(flushReq)
    );
    maac_checker #(.VA_BITS(VA)) u_maac_checker (
        .clk(clk),
        .arst_n(arst_n),
        .reqValid(reqValid),
        .reqOp(reqOp),
        .reqSize(reqSize),
        .reqBase(reqBase),
        .reqIndex(reqIndex),
        .reqImm(reqImm),
        .reqUseImm(reqUseImm),
        .reqAlt(reqAlt),
        .reqSpaceId(reqSpaceId),
        .reqStoreData(reqStoreData),
        .dataLittle(dataLittle),
        .privMode(privMode),
        .flushReq(flushReq),
        .issValid(issValid),
        .issOp(issOp),
        .issAddr(issAddr),
        .issSpaceId(issSpaceId),
        .issData(issData),
        .issImplRegs(issImplRegs),
        .faultValid(faultValid),
        .faultCode(faultCode),
        .faultAddr(faultAddr),
        .fetchBufDiscard(fetchBufDiscard),
        .fetchStale(fetchStale)
    );
    // Clock, 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(logic [63:0] seen, logic [63:0] exp);
        testsRun++;
        if (seen !== exp) begin
            nFail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic endSim();
        if (nFail == 0 && testsRun > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // One access at address a; flt is the expected fault code, zero if none
    task automatic acc(maac_op_t op, maac_size_t sz, logic [63:0] a,
        logic alt, logic [7:0] id, logic [2:0] flt);
        u_maac_pipe_model.send(op, sz, a, '0, '0, 1'b0, alt, id, '0);
        chk(issValid, flt == 3'h0);
        chk(faultValid, flt != 3'h0);
        if (flt != 3'h0) begin
            chk(faultCode, flt);
            chk(faultAddr, a);
        end else begin
            chk(issAddr, a);
            chk(issOp, op);
        end
    endtask
    // --------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------
    task automatic tForm();
        u_maac_pipe_model.send(MAAC_OP_STORE, MAAC_SZ_WORD, 64'h0, 64'h0,
            13'h0004, 1'b1, 1'b0, 8'h00, 64'h0);
        chk(issAddr, 64'h4);
        chk(issSpaceId, SPACE_DEFAULT_BE);
        u_maac_pipe_model.send(MAAC_OP_LOAD, MAAC_SZ_DWORD, 64'h10, 64'h0,
            13'h1FF8, 1'b1, 1'b0, 8'h00, 64'h0);
        chk(issAddr, 64'h8);
        u_maac_pipe_model.send(MAAC_OP_LOAD, MAAC_SZ_BYTE, 64'h100, 64'h8,
            13'h0000, 1'b0, 1'b0, 8'h00, 64'h0);
        chk(issAddr, 64'h108);
    endtask
    task automatic tAlign();
        for (int s = 1; s < 4; s++) begin
            acc(s[0] ? MAAC_OP_STORE : MAAC_OP_LOAD, maac_size_t'(s),
                64'h1 << (s - 1), 1'b0, 8'h00, 3'h1);
            acc(MAAC_OP_LOAD, maac_size_t'(s), 64'h1 << s, 1'b0, 8'h00,
                3'h0);
        end
        acc(MAAC_OP_CAS_W, MAAC_SZ_WORD, 64'h6, 1'b1, 8'h80, 3'h1);
        acc(MAAC_OP_LDST_UB, MAAC_SZ_BYTE, 64'h7, 1'b0, 8'h00, 3'h0);
    endtask
    task automatic tHole();
        lo = 64'h1 << (VA - 1);
        hi = ~lo + 64'h1;
        acc(MAAC_OP_LOAD, MAAC_SZ_BYTE, lo - 64'h1, 1'b0, 8'h00, 3'h0);
        acc(MAAC_OP_LOAD, MAAC_SZ_BYTE, lo, 1'b0, 8'h00, 3'h2);
        acc(MAAC_OP_LOAD, MAAC_SZ_BYTE, hi - 64'h1, 1'b0, 8'h00, 3'h2);
        acc(MAAC_OP_LOAD, MAAC_SZ_BYTE, hi, 1'b0, 8'h00, 3'h0);
    endtask
    // Every mode against the four boundary ids, plain and atomic accesses
    task automatic tPriv();
        logic ok;
        for (int m = 0; m < 3; m++) begin
            u_maac_pipe_model.setMode(maac_mode_t'(m));
            for (int i = 0; i < 8; i++) begin
                ok = ids[i%4] > SPACE_HYP_LAST || (ids[i%4] > SPACE_PRIV_LAST ?
                    m == 2 : m != 0);
                acc(i < 4 ? MAAC_OP_LOAD : MAAC_OP_CAS_X, MAAC_SZ_DWORD, 64'h8,
                    1'b1, ids[i%4], ok ? 3'h0 : 3'h4);
                if (ok) chk(issSpaceId, ids[i%4]);
            end
        end
        acc(MAAC_OP_STORE, MAAC_SZ_BYTE, 64'h0, 1'b1, SPACE_IMPL_REGS, 3'h0);
        chk(issImplRegs, 1'b1);
        acc(MAAC_OP_ANC_RD, MAAC_SZ_DWORD, 64'h3, 1'b0, 8'h00, 3'h0);
    endtask
    task automatic tEndian();
        for (int l = 0; l < 2; l++) begin
            u_maac_pipe_model.setLittle(l[0]);
            u_maac_pipe_model.send(MAAC_OP_STORE, MAAC_SZ_DWORD, 64'h0, 64'h0,
                13'h0000, 1'b0, 1'b0, 8'h00, 64'h0011223344556677);
            chk(issData, l ? 64'h7766554433221100 :
                64'h0011223344556677);
            chk(issSpaceId, l ? SPACE_DEFAULT_LE : SPACE_DEFAULT_BE);
        end
        // Fetch while little-endian data is selected must stay big-endian
        u_maac_pipe_model.send(MAAC_OP_FETCH, MAAC_SZ_DWORD, 64'h0, 64'h0,
            13'h0000, 1'b0, 1'b0, 8'h00, 64'h0011223344556677);
        chk(issValid, 1'b1);
        chk(issData, 64'h0011223344556677);
        chk(issSpaceId, SPACE_DEFAULT_BE);
        u_maac_pipe_model.setLittle(1'b0);
    endtask
    task automatic tFlush();
        acc(MAAC_OP_STORE, MAAC_SZ_WORD, 64'h40, 1'b0, 8'h00, 3'h0);
        chk(fetchStale, 1'b1);
        u_maac_pipe_model.flush();
        chk(fetchBufDiscard, 1'b1);
        chk(fetchStale, 1'b0);
    endtask
    // --------------------------------------------------------
    // Main sequence and watchdog
    // --------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        tForm();
        tAlign();
        tHole();
        tPriv();
        tEndian();
        tFlush();
        endSim();
    end
    initial begin
        #20us;
        nFail++;
        endSim();
    end
endmodule
